//--- hdl/gfm_top.sv
// Genset fault monitor: limit checks, alarm timers and AXI4-Lite registers.
//
// Local design decisions: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Stop timer expired, still running: fail-to-stop.
// - Start attempts exhausted, not running: fail-to-start.
// - Charge voltage below limit raises alarm.
// - Charge and unbalance checks wait for holdoff.
// - ECU silent three seconds raises alarm.
// - ECU check only while fuel is on.
// - Phase voltage off mean too long: alarm.
// - Phase current off mean too long: alarm.
// - Overcurrent held for inverse time: alarm.
// - Currents back below limit abandon detection.
// - Current unbalance and overcurrent actions are programmable.
// - Speed below crank cut too long: alarm.
// - Speed loss action has own setting.
// - Any expired service counter raises alarm.
// - Both buttons held five seconds reset counters.
module gfm_top
	import gfm_pkg::*;
#(
	parameter int TICK_CYCLES = TICK_CYCLES_DEF
)(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire logic ce_in,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire gfm_meas_s meas_in,
	input wire gfm_flag_s flags_in,
	output logic [NA-1:0] alarm_out,
	output gfm_resp_s resp_out,
	output logic svc_reset_out,
	output logic display_done_out,
	output logic irq_out
);
	// ****************************************
	// Functions
	// ****************************************
	// True when any phase departs from the mean by more than the limit.
	// Compared at three times scale so no divider is needed.
	function automatic logic unbal(input logic [2:0][15:0] ph,
		input logic [15:0] lim);
		logic [17:0] sum;
		logic [17:0] x3;
		logic hit;
		sum = 18'(ph[0]) + 18'(ph[1]) + 18'(ph[2]);
		hit = 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			x3 = 18'(ph[k]) * 18'd3;
			if (x3 > sum)
				hit = hit | ((x3 - sum) > 18'(lim) * 18'd3);
			else
				hit = hit | ((sum - x3) > 18'(lim) * 18'd3);
		end
		return hit;
	endfunction

	// Index of a configuration register, valid flag in the top bit.
	function automatic logic [4:0] cfg_dec(input logic [7:0] addr);
		logic [7:0] rel;
		rel = addr - OFS_CFG0;
		if (addr >= OFS_CFG0 && rel[1:0] == 2'b00 && rel[7:2] < 6'(NCFG))
			return {1'b1, rel[5:2]};
		return 5'h00;
	endfunction

	// Maps a response setting onto the three response lines.
	function automatic gfm_resp_s act_map(input logic [1:0] a);
		gfm_resp_s r;
		r.warning = (gfm_act_e'(a) == ACT_WARN);
		r.unload = (gfm_act_e'(a) == ACT_UNLOAD);
		r.shutdown = (gfm_act_e'(a) == ACT_SHUT);
		return r;
	endfunction

	// ****************************************
	// Declarations
	// ****************************************
	logic [NCFG-1:0][15:0] cfg, next_cfg;
	logic [NA-1:0] status, next_status;
	logic [NA-1:0] alarm_q, next_alarm;
	logic [15:0] pre, next_pre;
	logic tick;
	logic [15:0] hold_cnt, next_hold_cnt;
	logic checks_ok;
	logic [3:0] attempts, next_attempts;
	logic [15:0] btn_cnt, next_btn_cnt;
	logic btn_done, next_btn_done;
	logic svc_pulse, next_svc_pulse;
	logic both_btn;
	logic [NT-1:0] t_cond;
	logic [NT-1:0][15:0] t_lim;
	logic [15:0] t_cnt [NT];
	logic [NT-1:0] t_fire;
	logic [15:0] imax;
	logic oc_over;
	logic [15:0] oc_excess;
	logic [15:0] oc_idx;
	gfm_resp_s next_resp;
	logic aw_hold, next_aw_hold;
	logic w_hold, next_w_hold;
	logic [7:0] aw_addr, next_aw_addr;
	logic [31:0] w_data, next_w_data;
	logic [3:0] w_strb, next_w_strb;
	logic bvalid, next_bvalid;
	logic [1:0] bresp, next_bresp;
	logic rvalid, next_rvalid;
	logic [1:0] rresp, next_rresp;
	logic [31:0] rdata, next_rdata;
	logic [4:0] wdec, rdec;
	logic rd_take;

	// ****************************************
	// Tick, holdoff, attempts and buttons
	// ****************************************
	// A one-millisecond tick drives every programmable timer, so the
	// timers stay narrow at the cost of one tick of granularity.
	assign tick = (pre == 16'(TICK_CYCLES - 1));
	assign both_btn = &flags_in.button;
	assign checks_ok = flags_in.running && hold_cnt >= cfg[C_T_HOLD];

	always_comb
	begin
		next_pre = tick ? 16'h0000 : pre + 16'h0001;
		next_hold_cnt = hold_cnt;
		if (!flags_in.running)
			next_hold_cnt = 16'h0000;
		else if (tick && hold_cnt < cfg[C_T_HOLD])
			next_hold_cnt = hold_cnt + 16'h0001;
		next_attempts = attempts;
		if (flags_in.running)
			next_attempts = 4'h0;
		else if (flags_in.crank_end && attempts != 4'hf)
			next_attempts = attempts + 4'h1;
		next_btn_cnt = btn_cnt;
		next_btn_done = btn_done;
		next_svc_pulse = 1'b0;
		if (!both_btn)
		begin
			next_btn_cnt = 16'h0000;
			next_btn_done = 1'b0;
		end
		else if (tick && !btn_done)
		begin
			next_btn_cnt = btn_cnt + 16'h0001;
			if (btn_cnt + 16'h0001 >= BTN_TICKS)
			begin
				next_btn_done = 1'b1;
				next_svc_pulse = 1'b1;
			end
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			pre <= 16'h0000;
			hold_cnt <= 16'h0000;
			attempts <= 4'h0;
			btn_cnt <= 16'h0000;
			btn_done <= 1'b0;
			svc_pulse <= 1'b0;
		end
		else if (ce_in)
		begin
			pre <= next_pre;
			hold_cnt <= next_hold_cnt;
			attempts <= next_attempts;
			btn_cnt <= next_btn_cnt;
			btn_done <= next_btn_done;
			svc_pulse <= next_svc_pulse;
		end
	end

	// ****************************************
	// Duration timers
	// ****************************************
	// overcurrent pending only while a phase is over
	assign imax = (meas_in.curr[0] > meas_in.curr[1]) ?
		((meas_in.curr[0] > meas_in.curr[2]) ? meas_in.curr[0] :
		meas_in.curr[2]) : ((meas_in.curr[1] > meas_in.curr[2]) ?
		meas_in.curr[1] : meas_in.curr[2]);
	assign oc_over = imax > cfg[C_LIM_OC];
	assign oc_excess = oc_over ? imax - cfg[C_LIM_OC] : 16'h0000;
	assign oc_idx = oc_excess >> IDMT_SHIFT;

	always_comb
	begin
		// stop timer runs while a stop is commanded
		t_cond[T_STOP] = flags_in.stop_cmd;
		t_lim[T_STOP] = cfg[C_T_STOP];
		t_cond[T_VUB] = checks_ok && unbal(meas_in.volt, cfg[C_LIM_UNB]);
		t_lim[T_VUB] = cfg[C_T_VFAIL];
		t_cond[T_CUB] = checks_ok && unbal(meas_in.curr, cfg[C_LIM_UNB]);
		t_lim[T_CUB] = cfg[C_T_VFAIL];
		t_cond[T_OC] = oc_over;
		t_lim[T_OC] = IDMT_TRIP[(oc_idx > 16'h0007) ? 3'h7 : oc_idx[2:0]];
		t_cond[T_SPD] = flags_in.running && meas_in.speed < cfg[C_LIM_CCUT];
		t_lim[T_SPD] = cfg[C_T_SPD];
		// silence counted only with fuel on
		t_cond[T_ECU] = flags_in.fuel_on && !flags_in.ecu_msg;
		t_lim[T_ECU] = ECU_TICKS;
	end

	for (genvar g = 0; g < NT; g++)
	begin : g_tmr
		logic [15:0] next_cnt;
		assign t_fire[g] = t_cond[g] && t_cnt[g] >= t_lim[g];
		always_comb
		begin
			next_cnt = t_cnt[g];
			if (!t_cond[g])
				next_cnt = 16'h0000;
			else if (tick && t_cnt[g] != 16'hffff)
				next_cnt = t_cnt[g] + 16'h0001;
		end
		always_ff @(posedge clock_in)
		begin
			if (reset_in)
				t_cnt[g] <= 16'h0000;
			else if (ce_in)
				t_cnt[g] <= next_cnt;
		end
	end

	// ****************************************
	// Alarms, responses and status
	// ****************************************
	always_comb
	begin
		next_alarm = '0;
		next_alarm[A_FSTOP] = t_fire[T_STOP] && flags_in.running;
		next_alarm[A_FSTART] = !flags_in.running &&
			cfg[C_START_N] != 16'h0000 && 16'(attempts) >= cfg[C_START_N];
		next_alarm[A_CHG] = checks_ok && meas_in.charge < cfg[C_LIM_CHG];
		next_alarm[A_ECU] = t_fire[T_ECU];
		next_alarm[A_VUB] = t_fire[T_VUB];
		next_alarm[A_CUB] = t_fire[T_CUB];
		next_alarm[A_OC] = t_fire[T_OC];
		next_alarm[A_SPD] = t_fire[T_SPD];
		next_alarm[A_SVC] = |flags_in.svc_expired;
		next_alarm[A_SVCDONE] = next_svc_pulse;
		// Fixed responses first; programmable ones are ORed on top.
		next_resp.warning = next_alarm[A_CHG] || next_alarm[A_SVC];
		next_resp.unload = 1'b0;
		next_resp.shutdown = next_alarm[A_FSTOP] || next_alarm[A_FSTART] ||
			next_alarm[A_ECU] || next_alarm[A_VUB];
		if (next_alarm[A_CUB])
			next_resp = next_resp | act_map(cfg[C_ACTION][ACT_CUB_LSB +: 2]);
		if (next_alarm[A_OC])
			next_resp = next_resp | act_map(cfg[C_ACTION][ACT_OC_LSB +: 2]);
		if (next_alarm[A_SPD])
			next_resp = next_resp | act_map(cfg[C_ACTION][ACT_SPD_LSB +: 2]);
		// A read clears the status, but an alarm present wins the cycle.
		next_status = status;
		if (rd_take && s_axi_araddr == OFS_STATUS)
			next_status = '0;
		next_status = next_status | alarm_q;
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			alarm_q <= '0;
			resp_out <= '0;
			status <= '0;
		end
		else if (ce_in)
		begin
			alarm_q <= next_alarm;
			resp_out <= next_resp;
			status <= next_status;
		end
	end

	assign alarm_out = alarm_q;
	assign svc_reset_out = svc_pulse;
	assign display_done_out = svc_pulse;
	assign irq_out = |(status & cfg[C_MASK][NA-1:0]);

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign s_axi_awready = !aw_hold;
	assign s_axi_wready = !w_hold;
	assign s_axi_arready = !rvalid;
	assign s_axi_bvalid = bvalid;
	assign s_axi_bresp = bresp;
	assign s_axi_rvalid = rvalid;
	assign s_axi_rresp = rresp;
	assign s_axi_rdata = rdata;
	assign rd_take = ce_in && s_axi_arvalid && !rvalid;
	assign wdec = cfg_dec(aw_addr);
	assign rdec = cfg_dec(s_axi_araddr);

	// Address and data are caught independently; the write is done once
	// both are held and the previous response has been accepted.
	always_comb
	begin
		next_aw_hold = aw_hold;
		next_aw_addr = aw_addr;
		next_w_hold = w_hold;
		next_w_data = w_data;
		next_w_strb = w_strb;
		next_bvalid = bvalid && !s_axi_bready;
		next_bresp = bresp;
		next_cfg = cfg;
		if (s_axi_awvalid && !aw_hold)
		begin
			next_aw_hold = 1'b1;
			next_aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_hold)
		begin
			next_w_hold = 1'b1;
			next_w_data = s_axi_wdata;
			next_w_strb = s_axi_wstrb;
		end
		if (aw_hold && w_hold && !bvalid)
		begin
			next_aw_hold = 1'b0;
			next_w_hold = 1'b0;
			next_bvalid = 1'b1;
			next_bresp = wdec[4] ? RESP_OK : RESP_SLVERR;
			if (wdec[4])
			begin
				for (int b = 0; b < 2; b++)
					if (w_strb[b])
						next_cfg[wdec[3:0]][b*8 +: 8] = w_data[b*8 +: 8];
			end
		end
		next_rvalid = rvalid && !s_axi_rready;
		next_rresp = rresp;
		next_rdata = rdata;
		if (rd_take)
		begin
			next_rvalid = 1'b1;
			next_rresp = RESP_OK;
			next_rdata = 32'h0000_0000;
			if (s_axi_araddr == OFS_STATUS)
				next_rdata[NA-1:0] = status;
			else if (s_axi_araddr == OFS_ALARM)
				next_rdata[NA-1:0] = alarm_q;
			else if (rdec[4])
				next_rdata[15:0] = cfg[rdec[3:0]];
			else
				next_rresp = RESP_SLVERR;
		end
	end

	always_ff @(posedge clock_in)
	begin
		if (reset_in)
		begin
			aw_hold <= 1'b0;
			aw_addr <= 8'h00;
			w_hold <= 1'b0;
			w_data <= 32'h0000_0000;
			w_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= RESP_OK;
			rvalid <= 1'b0;
			rresp <= RESP_OK;
			rdata <= 32'h0000_0000;
			cfg <= CFG_RST;
		end
		else if (ce_in)
		begin
			aw_hold <= next_aw_hold;
			aw_addr <= next_aw_addr;
			w_hold <= next_w_hold;
			w_data <= next_w_data;
			w_strb <= next_w_strb;
			bvalid <= next_bvalid;
			bresp <= next_bresp;
			rvalid <= next_rvalid;
			rresp <= next_rresp;
			rdata <= next_rdata;
			cfg <= next_cfg;
		end
	end

	// ****************************************
	// Assertions
	// ****************************************
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);

	sequence s_stop_late;
		ce_in && t_fire[T_STOP] && flags_in.running;
	endsequence
	sequence s_both_held;
		both_btn && $past(both_btn);
	endsequence

	property p_fail_stop;
		s_stop_late |=> alarm_q[A_FSTOP] && resp_out.shutdown;
	endproperty
	a_fail_stop: assert property (p_fail_stop)
		else $error("fail-to-stop not raised");

	property p_fail_start;
		ce_in && !flags_in.running && cfg[C_START_N] != 16'h0000 &&
			16'(attempts) >= cfg[C_START_N] |=> alarm_q[A_FSTART];
	endproperty
	a_fail_start: assert property (p_fail_start)
		else $error("fail-to-start not raised");

	property p_holdoff;
		ce_in && !checks_ok |=>
			!alarm_q[A_CHG] && !alarm_q[A_VUB] && !alarm_q[A_CUB];
	endproperty
	a_holdoff: assert property (p_holdoff)
		else $error("check active during holdoff");

	property p_ecu_fuel;
		ce_in && !flags_in.fuel_on |=> t_cnt[T_ECU] == 16'h0000;
	endproperty
	a_ecu_fuel: assert property (p_ecu_fuel)
		else $error("ECU counter runs with fuel off");

	property p_oc_abandon;
		ce_in && !oc_over |=> t_cnt[T_OC] == 16'h0000 && !alarm_q[A_OC];
	endproperty
	a_oc_abandon: assert property (p_oc_abandon)
		else $error("overcurrent kept after currents fell");

	property p_svc_due;
		ce_in && |flags_in.svc_expired |=> alarm_q[A_SVC] ##1 status[A_SVC];
	endproperty
	a_svc_due: assert property (p_svc_due)
		else $error("service alarm missing");

	property p_svc_reset;
		$rose(svc_reset_out) |-> s_both_held and
			$past(btn_cnt) + 16'h0001 >= BTN_TICKS && display_done_out;
	endproperty
	a_svc_reset: assert property (p_svc_reset)
		else $error("service reset without full hold");

	property p_restart;
		ce_in && !t_cond[T_SPD] |=> t_cnt[T_SPD] == 16'h0000;
	endproperty
	a_restart: assert property (p_restart)
		else $error("speed timer not restarted");
endmodule
`default_nettype wire

//--- hdl/gfm_pkg.sv
// Constants, register map and carrier types of the genset fault monitor.
package gfm_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int CLK_HZ = 25_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES_DEF = CLK_HZ / 1_000_000 * TICK_US;
	localparam int ECU_TIMEOUT_MS = 3000;
	localparam int BTN_HOLD_MS = 5000;
	localparam logic [15:0] ECU_TICKS = 16'(ECU_TIMEOUT_MS * 1000 / TICK_US);
	localparam logic [15:0] BTN_TICKS = 16'(BTN_HOLD_MS * 1000 / TICK_US);
	// ****************************************
	// Register map (byte addresses)
	// ****************************************
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ALARM = 8'h04;
	localparam logic [7:0] OFS_CFG0 = 8'h08;
	localparam int NCFG = 11;
	localparam int C_MASK = 0;
	localparam int C_ACTION = 1;
	localparam int C_LIM_CHG = 2;
	localparam int C_LIM_UNB = 3;
	localparam int C_LIM_OC = 4;
	localparam int C_LIM_CCUT = 5;
	localparam int C_START_N = 6;
	localparam int C_T_STOP = 7;
	localparam int C_T_HOLD = 8;
	localparam int C_T_VFAIL = 9;
	localparam int C_T_SPD = 10;
	localparam logic [NCFG-1:0][15:0] CFG_RST = {
		16'h000a, 16'h000a, 16'h03e8, 16'h2710, 16'h0003, 16'h0064,
		16'h0100, 16'h0020, 16'h0010, 16'h0000, 16'h0000};
	localparam logic [1:0] RESP_OK = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// ****************************************
	// Alarm bits, timers and action fields
	// ****************************************
	localparam int NA = 10;
	localparam int A_FSTOP = 0;
	localparam int A_FSTART = 1;
	localparam int A_CHG = 2;
	localparam int A_ECU = 3;
	localparam int A_VUB = 4;
	localparam int A_CUB = 5;
	localparam int A_OC = 6;
	localparam int A_SPD = 7;
	localparam int A_SVC = 8;
	localparam int A_SVCDONE = 9;
	localparam int NT = 6;
	localparam int T_STOP = 0;
	localparam int T_VUB = 1;
	localparam int T_CUB = 2;
	localparam int T_OC = 3;
	localparam int T_SPD = 4;
	localparam int T_ECU = 5;
	localparam int ACT_CUB_LSB = 0;
	localparam int ACT_OC_LSB = 2;
	localparam int ACT_SPD_LSB = 4;
	// Inverse-time trip ticks, index grows with the current excess.
	localparam int IDMT_SHIFT = 4;
	localparam logic [7:0][15:0] IDMT_TRIP = {16'h0032, 16'h0064,
		16'h00c8, 16'h01f4, 16'h03e8, 16'h09c4, 16'h1388, 16'h2710};
	// ****************************************
	// Types
	// ****************************************
	typedef enum logic [1:0] {
		ACT_NONE = 2'b00,
		ACT_WARN = 2'b01,
		ACT_UNLOAD = 2'b10,
		ACT_SHUT = 2'b11
	} gfm_act_e;
	typedef struct packed {
		logic [2:0][15:0] volt;
		logic [2:0][15:0] curr;
		logic [15:0] charge;
		logic [15:0] speed;
	} gfm_meas_s;
	typedef struct packed {
		logic running;
		logic stop_cmd;
		logic crank_end;
		logic fuel_on;
		logic ecu_msg;
		logic [3:0] svc_expired;
		logic [1:0] button;
	} gfm_flag_s;
	typedef struct packed {
		logic warning;
		logic unload;
		logic shutdown;
	} gfm_resp_s;
endpackage

//--- dv/gfm_plant.sv
// Engine, generator and engine-controller stand-in for the monitor bench.
`timescale 1ns/10ps
`default_nettype none
module gfm_plant
	import gfm_pkg::*;
(
	input wire logic clock_in,
	input wire logic reset_in,
	input wire gfm_flag_s cmd_in,
	output var gfm_flag_s flags_out
);
	// ****************************************
	// Engine side
	// ****************************************
	logic [6:0] gap;
	logic [6:0] next_gap;
	logic crank_d;
	// The message gap runs free so pulses keep a steady spacing.
	always_comb
	begin
		next_gap = gap + 7'h01;
	end
	always_ff @(posedge clock_in)
	begin
		gap <= reset_in ? 7'h00 : next_gap;
		crank_d <= reset_in ? 1'b0 : cmd_in.crank_end;
	end
	// Levels pass through; messages and crank ends become single pulses.
	always_comb
	begin
		flags_out = cmd_in;
		flags_out.ecu_msg = cmd_in.ecu_msg & cmd_in.fuel_on & (gap == 7'h00);
		flags_out.crank_end = cmd_in.crank_end & ~crank_d;
		flags_out.button = cmd_in.button;
	end
endmodule
`default_nettype wire

//--- dv/gfm_tb_top.sv
// Self-checking bench for the genset fault monitor.
`timescale 1ns/10ps
`default_nettype none
module gfm_tb_top;
	import gfm_pkg::*;
	// ****************************************
	// Signals and instances
	// ****************************************
	localparam int TK = 4;
	localparam logic [2:0] RTAB [4] = '{3'b000, 3'b100, 3'b010, 3'b001};
	localparam gfm_meas_s NOM = {{3{16'h0100}}, {3{16'h0040}}, 16'h0100,
		16'h0200};
	logic clock_in = 1'b0;
	logic reset_in = 1'b1;
	logic ce_in = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic s_axi_awready;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic [NA-1:0] alarm_out;
	gfm_resp_s resp_out;
	logic svc_reset_out;
	logic display_done_out;
	logic irq_out;
	gfm_meas_s meas_in;
	gfm_flag_s cmd;
	gfm_flag_s flags_in;
	int mismatches = 0;
	int compares = 0;
	int pulses = 0;
	int dones = 0;
	gfm_top #(.TICK_CYCLES(TK)) dut (.clock_in, .reset_in, .ce_in,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .meas_in, .flags_in, .alarm_out, .resp_out,
		.svc_reset_out, .display_done_out, .irq_out);
	gfm_plant plant (.clock_in, .reset_in, .cmd_in(cmd),
		.flags_out(flags_in));
	always #20 clock_in = ~clock_in;
	// Service reset pulses are counted so none slips by between checks.
	always @(posedge clock_in)
	begin
		pulses <= pulses + svc_reset_out;
		dones <= dones + display_done_out;
	end
	// ****************************************
	// Helpers
	// ****************************************
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e)
		begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, s, e);
		end
	endtask
	// Waits end on a falling edge, where outputs have settled.
	task automatic tk(input int n);
		repeat (n * TK) @(negedge clock_in);
	endtask
	// Write: address and data offered together, each dropped when taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		logic ta;
		logic tw;
		logic g;
		logic [1:0] r;
		g = 1'b0;
		r = 2'b00;
		@(posedge clock_in);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// No latency is assumed; only the watchdog ends a stuck wait.
		while (!g)
		begin
			@(negedge clock_in);
			ta = s_axi_awvalid & s_axi_awready;
			tw = s_axi_wvalid & s_axi_wready;
			g = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge clock_in);
			if (ta)
				s_axi_awvalid <= 1'b0;
			if (tw)
				s_axi_wvalid <= 1'b0;
		end
		s_axi_bready <= 1'b0;
		chk(g, 1'b1);
		chk(r, er);
	endtask
	// Read: the answer is taken at the edge where rvalid is seen.
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		logic ta;
		logic g;
		logic [1:0] r;
		g = 1'b0;
		r = 2'b00;
		d = 32'h0;
		@(posedge clock_in);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!g)
		begin
			@(negedge clock_in);
			ta = s_axi_arvalid & s_axi_arready;
			g = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge clock_in);
			if (ta)
				s_axi_arvalid <= 1'b0;
		end
		s_axi_rready <= 1'b0;
		chk(g, 1'b1);
		chk(r, er);
	endtask
	task automatic end_of_test();
		if (mismatches == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// ****************************************
	// Scenarios
	// ****************************************
	// Reset values, unmapped and read-only places, upper bits dropped.
	task automatic s_regs();
		logic [31:0] d;
		for (int i = 0; i < NCFG; i++)
		begin
			rd(OFS_CFG0 + 8'(4 * i), d, RESP_OK);
			chk(d, 32'(CFG_RST[i]));
		end
		rd(8'h34, d, RESP_SLVERR);
		chk(d, 32'h0);
		wr(OFS_ALARM, 32'h1, RESP_SLVERR);
		wr(8'h28, 32'h5, RESP_OK);
		wr(8'h24, 32'hffff0014, RESP_OK);
		rd(8'h24, d, RESP_OK);
		chk(d, 32'h14);
	endtask
	// Three failed crank attempts while stopped.
	task automatic s_start();
		for (int i = 0; i < 3; i++)
		begin
			chk(alarm_out[A_FSTART], 1'b0);
			@(posedge clock_in);
			cmd.crank_end <= 1'b1;
			@(posedge clock_in);
			cmd.crank_end <= 1'b0;
			tk(1);
		end
		chk(alarm_out[A_FSTART], 1'b1);
		chk(resp_out, 3'b001);
	endtask
	// Low charge from the first moment of running; holdoff must mask it.
	task automatic s_charge();
		@(posedge clock_in);
		cmd.running <= 1'b1;
		meas_in.charge <= 16'h0000;
		tk(2);
		chk(alarm_out[A_FSTART], 1'b0);
		chk(alarm_out[A_CHG], 1'b0);
		tk(10);
		chk(alarm_out[A_CHG], 1'b1);
		@(posedge clock_in);
		meas_in.charge <= NOM.charge;
		tk(2);
		chk(alarm_out[A_CHG], 1'b0);
	endtask
	// A one-cycle gap in the unbalance must restart its timer.
	task automatic s_vub();
		@(posedge clock_in);
		meas_in.volt <= {16'h0200, 16'h0100, 16'h0100};
		tk(6);
		@(posedge clock_in);
		meas_in.volt <= NOM.volt;
		@(posedge clock_in);
		meas_in.volt <= {16'h0200, 16'h0100, 16'h0100};
		tk(8);
		chk(alarm_out[A_VUB], 1'b0);
		tk(6);
		chk(alarm_out[A_VUB], 1'b1);
		chk(resp_out, 3'b001);
		@(posedge clock_in);
		meas_in.volt <= NOM.volt;
		tk(2);
	endtask
	// Every action code on the current unbalance alarm.
	task automatic s_cub();
		for (int a = 0; a < 4; a++)
		begin
			wr(8'h0c, 32'(a), RESP_OK);
			@(posedge clock_in);
			meas_in.curr <= {16'h0050, 16'h0010, 16'h0010};
			tk(14);
			chk(alarm_out[A_CUB], 1'b1);
			chk(resp_out, RTAB[a]);
			@(posedge clock_in);
			meas_in.curr <= NOM.curr;
			tk(2);
		end
	endtask
	// Largest excess trips in 50 ticks; an early drop abandons the count.
	task automatic s_oc();
		wr(8'h0c, 32'h4, RESP_OK);
		@(posedge clock_in);
		meas_in.curr <= {3{16'h0175}};
		tk(30);
		@(posedge clock_in);
		meas_in.curr <= NOM.curr;
		tk(2);
		chk(alarm_out[A_OC], 1'b0);
		@(posedge clock_in);
		meas_in.curr <= {3{16'h0175}};
		tk(45);
		chk(alarm_out[A_OC], 1'b0);
		tk(15);
		chk(alarm_out[A_OC], 1'b1);
		chk(resp_out, 3'b100);
		@(posedge clock_in);
		meas_in.curr <= NOM.curr;
		tk(2);
	endtask
	// Pickup speed lost while running, answered by unloading.
	task automatic s_spd();
		wr(8'h0c, 32'h20, RESP_OK);
		@(posedge clock_in);
		meas_in.speed <= 16'h0000;
		tk(6);
		chk(alarm_out[A_SPD], 1'b0);
		// With the clock enable low the loss timer must stay frozen.
		@(posedge clock_in);
		ce_in <= 1'b0;
		tk(20);
		chk(alarm_out[A_SPD], 1'b0);
		@(posedge clock_in);
		ce_in <= 1'b1;
		tk(8);
		chk(alarm_out[A_SPD], 1'b1);
		chk(resp_out, 3'b010);
		@(posedge clock_in);
		meas_in.speed <= NOM.speed;
		tk(2);
	endtask
	// Engine keeps running past the 20-tick stop timer.
	task automatic s_stop();
		@(posedge clock_in);
		cmd.stop_cmd <= 1'b1;
		tk(15);
		chk(alarm_out[A_FSTOP], 1'b0);
		tk(10);
		chk(alarm_out[A_FSTOP], 1'b1);
		chk(resp_out, 3'b001);
		@(posedge clock_in);
		cmd.running <= 1'b0;
		cmd.stop_cmd <= 1'b0;
		tk(2);
		chk(alarm_out[A_FSTOP], 1'b0);
	endtask
	// Silence with fuel off is ignored; with fuel on it trips at 3000.
	task automatic s_ecu();
		tk(3100);
		chk(alarm_out[A_ECU], 1'b0);
		@(posedge clock_in);
		cmd.fuel_on <= 1'b1;
		cmd.ecu_msg <= 1'b1;
		tk(1000);
		chk(alarm_out[A_ECU], 1'b0);
		@(posedge clock_in);
		cmd.ecu_msg <= 1'b0;
		tk(2950);
		chk(alarm_out[A_ECU], 1'b0);
		tk(100);
		chk(alarm_out[A_ECU], 1'b1);
		@(posedge clock_in);
		cmd.fuel_on <= 1'b0;
		tk(2);
		chk(alarm_out[A_ECU], 1'b0);
	endtask
	// Service due raises the interrupt only when unmasked; read clears.
	task automatic s_irq();
		logic [31:0] d;
		@(posedge clock_in);
		cmd.svc_expired <= 4'h2;
		tk(1);
		chk(alarm_out[A_SVC], 1'b1);
		chk(resp_out, 3'b100);
		wr(OFS_CFG0, 32'h0, RESP_OK);
		tk(1);
		chk(irq_out, 1'b0);
		wr(OFS_CFG0, 32'h100, RESP_OK);
		tk(1);
		chk(irq_out, 1'b1);
		@(posedge clock_in);
		cmd.svc_expired <= 4'h0;
		tk(1);
		rd(OFS_STATUS, d, RESP_OK);
		chk(d[A_SVC], 1'b1);
		rd(OFS_STATUS, d, RESP_OK);
		chk(d[A_SVC], 1'b0);
		tk(1);
		chk(irq_out, 1'b0);
	endtask
	// A short release aborts the hold; a full 5000-tick hold resets.
	task automatic s_svc();
		logic [31:0] d;
		@(posedge clock_in);
		cmd.button <= 2'b11;
		tk(2000);
		@(posedge clock_in);
		cmd.button <= 2'b01;
		@(posedge clock_in);
		cmd.button <= 2'b11;
		tk(3100);
		chk(pulses, 0);
		tk(2000);
		chk(pulses, 1);
		chk(dones, 1);
		rd(OFS_STATUS, d, RESP_OK);
		chk(d[A_SVCDONE], 1'b1);
		@(posedge clock_in);
		cmd.button <= 2'b00;
	endtask
	// ****************************************
	// Sequence and watchdog
	// ****************************************
	initial
	begin
		meas_in = NOM;
		cmd = '0;
		repeat (8) @(posedge clock_in);
		reset_in <= 1'b0;
		s_regs();
		s_start();
		s_charge();
		s_vub();
		s_cub();
		s_oc();
		s_spd();
		s_stop();
		s_ecu();
		s_irq();
		s_svc();
		end_of_test();
	end
	// The run needs about 58000 cycles; this limit leaves a margin.
	initial
	begin
		repeat (90000) @(posedge clock_in);
		mismatches++;
		end_of_test();
	end
endmodule
`default_nettype wire
